// ===== pkg/asd_map.svh
// constants of the add/subtract datapath: field positions and codes
// assumes the includer uses these only as sized constants
`ifndef ASD_MAP_SVH
`define ASD_MAP_SVH
`define ASD_DATA_W      32
`define ASD_IMM_W       12
`define ASD_REG_W       4
`define ASD_REG_STACK   4'hD
`define ASD_REG_PC      4'hF
`define ASD_FLAG_N      3
`define ASD_FLAG_Z      2
`define ASD_FLAG_C      1
`define ASD_FLAG_V      0
`define ASD_FLAGS_RST   4'h0
`endif

// ===== pkg/asd_pkg.sv
// types of the add/subtract datapath
// assumes asd_map.svh holds the numeric constants
package asd_pkg;
  typedef enum logic [2:0] {
    ASD_OP_ADD,
    ASD_OP_ADC,
    ASD_OP_SUB,
    ASD_OP_SUBTRACT_WITH_CARRY,
    ASD_OP_REVERSE_SUBTRACT
  } asd_op_t;
endpackage

// ===== pkg/asd_add_if.sv
// adder operands and result travelling between the top and its adder
// assumes one clock domain; purely combinational carrier
`timescale 1ns/100ps
interface asd_add_if #(parameter int W = 32);
  logic [W-1:0] a;
  logic [W-1:0] b;
  logic         cin;
  logic [W-1:0] sum;
  logic         cout;
  logic         ovf;
  modport user  (output a, output b, output cin,
                 input sum, input cout, input ovf);
  modport adder (input a, input b, input cin,
                 output sum, output cout, output ovf);
endinterface // asd_add_if

// ===== hw/asd_adder.sv
// full adder of W bits with carry out and signed overflow
// assumes operands already inverted by the caller for subtraction
`timescale 1ns/100ps
module asd_adder #(
  parameter int W = 32
) (
  asd_add_if.adder bus
);
  logic [W:0] wide;

  // one adder serves every operation, subtraction by inverted operand
  assign wide     = {1'b0, bus.a} + {1'b0, bus.b} + {{W{1'b0}}, bus.cin};
  assign bus.sum  = wide[W-1:0];
  assign bus.cout = wide[W];
  // signed overflow: like-signed inputs give a result of the other sign
  assign bus.ovf  = (bus.a[W-1] == bus.b[W-1]) &&
                    (bus.sum[W-1] != bus.a[W-1]);
endmodule // asd_adder

// ===== hw/asd_datapath.sv
// add/subtract datapath: add, add with carry, subtract, subtract with
// carry, reverse subtract, with flag update and program counter branch
// assumes the decoder supplies operand values already read from the
// register file and keeps the operand legality limits listed below;
// results come out registered at the taking edge, with no forwarding
// of a result into the operands of the very next instruction
`timescale 1ns/100ps
`include "asd_map.svh"
module asd_datapath
  import asd_pkg::*;
#(
  parameter int W = `ASD_DATA_W
) (
  input  wire logic                  i_core_clk,
  input  wire logic                  i_rst,
  input  wire logic                  i_valid,
  input  wire asd_op_t               i_op,
  input  wire logic                  i_set_flags,
  input  wire logic                  i_use_imm,
  input  wire logic                  i_wide_imm,
  input  wire logic                  i_cond_pass,
  input  wire logic [`ASD_REG_W-1:0] i_first_operand_register,
  input  wire logic [W-1:0]          i_first_operand_value,
  input  wire logic [W-1:0]          i_flexible_second_operand,
  input  wire logic                  i_flexible_carry,
  input  wire logic [`ASD_IMM_W-1:0] i_twelve_bit_immediate,
  input  wire logic                  i_dest_present,
  input  wire logic [`ASD_REG_W-1:0] i_dest_register,
  output logic                       o_wr_en,
  output logic [`ASD_REG_W-1:0]      o_wr_register,
  output logic [W-1:0]               o_wr_data,
  output logic                       o_branch,
  output logic [W-1:0]               o_branch_target,
  output logic [3:0]                 o_flags
);
  // far-side duties, not checked here: the decoder never offers the
  // stack or program counter as the second operand, names the stack as
  // a destination only for add or subtract from the stack with a left
  // shift of at most three, offers the stack as first operand only in
  // plain add and subtract, and offers the program counter as first
  // operand only unflagged with an immediate; a conditional pc-plus-
  // register add comes last in its conditional block and sets no flags.
  // checking these here would cost a copy of the decoder for no gain,
  // since an illegal mix still yields a defined, if useless, result

  // the shared adder sits behind an interface so that operand steering
  // and the arithmetic itself stay separate concerns
  asd_add_if #(.W(W)) add_bus ();

  // flag state, operand steering and write-back decisions
  logic [3:0]          flags_q;
  logic [3:0]          flags_d;
  logic [W-1:0]        base;
  logic [W-1:0]        second;
  logic                is_sub;
  logic [`ASD_REG_W-1:0] dest;
  logic                do_op;
  logic                res_neg;
  logic                res_zero;
  logic                res_carry;
  logic                res_ovf;
  logic                to_pc;
  logic [W-1:0]        branch_addr;

  // the core drives the flags from this register only
  assign o_flags = flags_q;
  assign do_op   = i_valid && i_cond_pass;

  // pc reads word aligned as a base value; the raw low bits still
  // arrive from the register file and are simply not used here
  always_comb begin
    base = i_first_operand_value;
    if (i_first_operand_register == `ASD_REG_PC) begin
      base = {i_first_operand_value[W-1:2], 2'b00};
    end
  end

  // the immediate path covers the wide forms too, so the decoder
  // need not tell them apart beyond the flag it already raises
  always_comb begin
    second = i_flexible_second_operand;
    if (i_use_imm || i_wide_imm) begin
      second = {{(W-`ASD_IMM_W){1'b0}}, i_twelve_bit_immediate};
    end
  end

  // operand steering into the shared adder
  always_comb begin
    add_bus.a   = base;
    add_bus.b   = second;
    add_bus.cin = 1'b0;
    is_sub      = 1'b0;
    unique case (i_op)
      // plain sum, no carry in
      ASD_OP_ADD: begin
        add_bus.cin = 1'b0;
      end
      // carry flag of the previous flagged op chains multiword sums
      ASD_OP_ADC: begin
        add_bus.cin = flags_q[`ASD_FLAG_C];
      end
      // a + ~b + 1 is a - b in two's complement
      ASD_OP_SUB: begin
        add_bus.b   = ~second;
        add_bus.cin = 1'b1;
        is_sub      = 1'b1;
      end
      // a clear carry means a borrow is owed, so one less is added
      ASD_OP_SUBTRACT_WITH_CARRY: begin
        add_bus.b   = ~second;
        add_bus.cin = flags_q[`ASD_FLAG_C];
        is_sub      = 1'b1;
      end
      // operands swap, the inverted one is now the base
      ASD_OP_REVERSE_SUBTRACT: begin
        add_bus.a   = second;
        add_bus.b   = ~base;
        add_bus.cin = 1'b1;
        is_sub      = 1'b1;
      end
      default: begin
        add_bus.cin = 1'b0;
      end
    endcase
  end

  asd_adder #(.W(W)) u_adder (
    .bus (add_bus)
  );

  // absent destination writes back the first operand register
  assign dest = i_dest_present ? i_dest_register
                               : i_first_operand_register;

  // any program counter destination turns into a branch; legality of
  // that form is the decoder's business
  assign to_pc = (dest == `ASD_REG_PC);

  // result flags of the adder, named so the update below reads plainly;
  // carry out of the inverted-operand add is the no-borrow flag
  assign res_neg   = add_bus.sum[W-1];
  assign res_zero  = (add_bus.sum == '0);
  assign res_carry = add_bus.cout;
  assign res_ovf   = add_bus.ovf;

  // bit zero of the written value is ignored, never trapped on
  assign branch_addr = {add_bus.sum[W-1:1], 1'b0};

  // flags move only on a taken op that asks for it
  always_comb begin
    flags_d = flags_q;
    if (do_op && i_set_flags) begin
      flags_d[`ASD_FLAG_N] = res_neg;
      flags_d[`ASD_FLAG_Z] = res_zero;
      flags_d[`ASD_FLAG_C] = res_carry;
      flags_d[`ASD_FLAG_V] = res_ovf;
    end
  end

  // multiword arithmetic chains through this carry, so a failed
  // condition or an unflagged op must leave every flag exactly as it was;
  // reset clears all four flags
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      flags_q <= `ASD_FLAGS_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // register write back; pc destination becomes a branch instead.
  // index and data follow every cycle, only the strobe qualifies them
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_wr_en       <= 1'b0;
      o_wr_register <= '0;
      o_wr_data     <= '0;
    end else begin
      o_wr_en       <= do_op && !to_pc;
      o_wr_register <= dest;
      o_wr_data     <= add_bus.sum;
    end
  end

  // the written bit zero is dropped, so the branch is halfword aligned;
  // the decoder keeps S off and the block-final ordering for this form
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      o_branch        <= 1'b0;
      o_branch_target <= '0;
    end else begin
      o_branch        <= do_op && to_pc;
      o_branch_target <= branch_addr;
    end
  end

  // unused flexible carry: shifter carry only matters to logical ops;
  // it stays on the port so the decoder wiring matches the logical unit,
  // and the subtract marker is kept for a later carry-select adder
  logic unused_ok;
  assign unused_ok = i_flexible_carry ^ is_sub;
endmodule // asd_datapath

// ===== sim/asd_datapath_props.sv
// assertions on the ports of the add/subtract datapath
// assumes binding onto asd_datapath at its default width
`timescale 1ns/100ps
module asd_datapath_props
  import asd_pkg::*;
(
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_valid,
  input wire asd_op_t     i_op,
  input wire logic        i_set_flags,
  input wire logic        i_use_imm,
  input wire logic        i_wide_imm,
  input wire logic        i_cond_pass,
  input wire logic [3:0]  i_first_operand_register,
  input wire logic [31:0] i_first_operand_value,
  input wire logic [31:0] i_flexible_second_operand,
  input wire logic [11:0] i_twelve_bit_immediate,
  input wire logic        i_dest_present,
  input wire logic [3:0]  i_dest_register,
  input wire logic        o_wr_en,
  input wire logic [3:0]  o_wr_register,
  input wire logic [31:0] o_wr_data,
  input wire logic        o_branch,
  input wire logic [31:0] o_branch_target,
  input wire logic [3:0]  o_flags
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // operands as the adder must see them; a pc base is word aligned
  wire tk = i_valid && i_cond_pass;
  wire [3:0] dst = i_dest_present ? i_dest_register : i_first_operand_register;
  wire wr = tk && dst != 4'hF;
  wire [31:0] a = (i_first_operand_register == 4'hF) ?
    {i_first_operand_value[31:2], 2'h0} : i_first_operand_value;
  wire [31:0] b = (i_use_imm || i_wide_imm) ?
    {20'h0, i_twelve_bit_immediate} : i_flexible_second_operand;
  a_wr_dest: assert property (
    wr |=> o_wr_en && o_wr_register == $past(dst)) else $error("bad dest");
  a_branch_pc: assert property (
    tk && dst == 4'hF |=> o_branch && !o_wr_en && !o_branch_target[0])
    else $error("bad branch");
  a_no_write: assert property (
    !tk |=> !o_wr_en && !o_branch) else $error("write when idle");
  a_flags_hold: assert property (
    !(tk && i_set_flags) |=> $stable(o_flags)) else $error("flags moved");
  a_add_sum: assert property (
    wr && i_op == ASD_OP_ADD |=> o_wr_data == $past(a + b)) else $error("sum");
  a_sub_diff: assert property (
    wr && i_op == ASD_OP_SUB |=> o_wr_data == $past(a - b))
    else $error("diff");
  a_nz_flags: assert property (
    wr && i_set_flags |=> o_flags[3:2] == {o_wr_data[31], o_wr_data == 32'h0})
    else $error("bad n or z");
  a_sub_carry: assert property (
    wr && i_set_flags && i_op == ASD_OP_SUB |=>
    o_flags[1] == ($past(a) >= $past(b))) else $error("bad borrow");
endmodule // asd_datapath_props

// ===== sim/asd_regfile_model.sv
// register file on the far side, answering operand reads at once
// assumes write-backs arrive as one-cycle pulses on the core clock
`timescale 1ns/100ps
module asd_regfile_model (
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_wr_en,
  input  wire logic [3:0]  i_rd_idx,
  input  wire logic [3:0]  i_wr_idx,
  input  wire logic [31:0] i_wr_data,
  output logic [31:0]      o_rd_val
);
  logic [31:0] regs_q [16];
  // pc keeps raw low bits set so that base alignment is exercised
  always_ff @(posedge i_core_clk or posedge i_rst) begin
    if (i_rst) begin
      regs_q <= '{15: 32'h1003, default: 32'h0};
    end else if (i_wr_en) begin
      regs_q[i_wr_idx] <= i_wr_data;
    end
  end
  assign o_rd_val = regs_q[i_rd_idx];
endmodule // asd_regfile_model

// ===== sim/asd_datapath_tb_top.sv
// bench: corner cases then seeded random ops, checked one edge later
// assumes the props checker and register file model are compiled
`timescale 1ns/100ps
module asd_datapath_tb_top import asd_pkg::*; ();
  logic clk = 1'h0, rst = 1'h1, vld = 1'h0, sf, ui, wi, cp, dp, wr_en, br;
  asd_op_t     op = ASD_OP_ADD;
  logic [3:0]  rn = 4'h0, rd, ef = 4'h0, wr_reg, fl;
  logic [11:0] im;
  logic [31:0] av, b, wr_data, tgt;
  int          bad_count = 0, cmp_count = 0;
  asd_datapath dut (.i_core_clk(clk), .i_rst(rst), .i_valid(vld), .i_op(op),
    .i_set_flags(sf), .i_use_imm(ui), .i_wide_imm(wi), .i_cond_pass(cp),
    .i_first_operand_register(rn), .i_first_operand_value(av),
    .i_flexible_second_operand(b), .i_flexible_carry(1'h0),
    .i_twelve_bit_immediate(im), .i_dest_present(dp), .i_dest_register(rd),
    .o_wr_en(wr_en), .o_wr_register(wr_reg), .o_wr_data(wr_data),
    .o_branch(br), .o_branch_target(tgt), .o_flags(fl));
  asd_regfile_model u_rf (.i_core_clk(clk), .i_rst(rst), .i_wr_en(wr_en),
    .i_rd_idx(rn), .i_wr_idx(wr_reg), .i_wr_data(wr_data), .o_rd_val(av));
  initial forever #5 clk = ~clk;
  // expected {n,z,c,v,result}; subtraction is add of the inverse plus one, or plus the carry flag for subtract with carry
  function automatic logic [35:0] calc(asd_op_t o, logic [31:0] a, v, logic c);
    logic [31:0] x, y;
    logic [32:0] s;
    x = (o == ASD_OP_REVERSE_SUBTRACT) ? ~a : a;
    y = (o == ASD_OP_SUB || o == ASD_OP_SUBTRACT_WITH_CARRY) ? ~v : v;
    s = x + y + ((o == ASD_OP_ADC || o == ASD_OP_SUBTRACT_WITH_CARRY) ? c
                 : o != ASD_OP_ADD);
    return {s[31], s[31:0] == 32'h0, s[32], x[31] == y[31] && s[31] != x[31],
            s[31:0]};
  endfunction
  task automatic chk(logic [35:0] g, x);
    cmp_count++;
    if (g !== x) begin
      bad_count++;
      $display("Error at %0t: got %h expected %h", $time, g, x);
    end
  endtask
  // called at a falling edge, so calls run back to back
  task automatic run(asd_op_t o, logic [3:0] n, d, logic p, s, u, w,
                     logic [11:0] i, logic [31:0] v, logic c);
    logic [35:0] e;
    logic [3:0] t;
    {op, rn, rd, dp, sf, ui, wi} = {o, n, d, p, s, u, w};
    {im, b, cp, vld} = {i, v, c, 1'h1};
    #1;
    e = calc(o, n == 4'hF ? {av[31:2], 2'h0} : av,
             u | w ? {20'h0, i} : v, ef[1]);
    t = p ? d : n;
    @(negedge clk);
    chk({wr_en, br}, {c && t != 4'hF, c && t == 4'hF});
    if (c && t == 4'hF) chk(tgt, {e[31:1], 1'h0});
    if (c && t != 4'hF) chk({wr_reg, wr_data}, {t, e[31:0]});
    if (c && s) ef = e[35:32];
    chk(fl, ef);
  endtask
  task automatic summarize();
    $display("compares %0d mismatches %0d", cmp_count, bad_count);
    if (bad_count == 0 && cmp_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    void'($urandom(78));
    repeat (10) @(negedge clk);
    rst = 1'h0;
    run(ASD_OP_ADD, 0, 1, 1, 0, 0, 0, 0, 32'h7FFFFFFF, 1);
    run(ASD_OP_ADD, 1, 2, 1, 1, 0, 0, 0, 32'h1, 1);
    run(ASD_OP_SUB, 0, 0, 0, 1, 0, 0, 0, 32'h1, 1);
    run(ASD_OP_SUBTRACT_WITH_CARRY, 2, 3, 1, 1, 0, 0, 0, 32'h0, 1);
    run(ASD_OP_ADC, 3, 6, 1, 1, 0, 0, 0, 32'h1, 1);
    run(ASD_OP_ADD, 15, 4, 1, 0, 1, 0, 12'hFFF, 0, 1);
    run(ASD_OP_SUB, 15, 5, 1, 0, 0, 1, 12'h0, 0, 1);
    run(ASD_OP_ADD, 13, 13, 1, 0, 0, 0, 0, 32'h8, 1);
    run(ASD_OP_ADD, 15, 15, 1, 0, 0, 0, 0, 32'h5, 1);
    run(ASD_OP_REVERSE_SUBTRACT, 4, 0, 0, 1, 0, 0, 0, 32'h0, 0);
    $display("corner cases done, mismatches %0d", bad_count);
    for (int k = 0; k < 400; k++)
      run(asd_op_t'($urandom_range(4)), 4'($urandom_range(12)),
          4'($urandom_range(12)), 1'($urandom), 1'($urandom), 1'($urandom),
          1'($urandom), 12'($urandom), $urandom,
          $urandom_range(7) != 0);
    vld = 1'h0;
    @(negedge clk);
    chk({wr_en, br}, 36'h0);
    $display("random ops done, mismatches %0d", bad_count);
    summarize();
  end
endmodule // asd_datapath_tb_top
bind asd_datapath asd_datapath_props u_props (.i_core_clk, .i_rst, .i_valid,
  .i_op, .i_set_flags, .i_use_imm, .i_wide_imm, .i_cond_pass,
  .i_first_operand_register, .i_first_operand_value,
  .i_flexible_second_operand, .i_twelve_bit_immediate, .i_dest_present,
  .i_dest_register, .o_wr_en, .o_wr_register, .o_wr_data, .o_branch,
  .o_branch_target, .o_flags);
